// [logic/mms_pkg.sv]
package mms_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] A_CLEAR = 8'h03;
  localparam logic [7:0] A_PHASE = 8'h37;
  localparam logic [7:0] A_VSTAT = 8'h80;
  localparam logic [7:0] A_FREQ = 8'hc0;
  localparam logic [7:0] A_NVM_OP = 8'hc1;
  localparam logic [7:0] A_USER = 8'hd1;
  localparam logic [7:0] A_RAIL = 8'hd3;
  localparam logic [7:0] A_GROUP = 8'he2;
  localparam logic [7:0] A_GUARD = 8'hfa;
  localparam logic [7:0] A_KEY = 8'hfb;
  localparam logic [7:0] A_LOCK = 8'hfd;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int U_SYNC_OUT = 0;
  localparam int U_SYNC_EXT = 1;
  localparam int U_SPREAD = 2;
  localparam int PH_OVR = 7;
  localparam int VS_EXT_FLT = 3;
  localparam int VS_GRP_FLT = 4;
  localparam int VS_LOC_FLT = 5;
  localparam int GRP_BCAST = 7;
  localparam int NV_SAVE = 2;
  localparam int NV_RESTORE = 3;

  // ****************************************
  // Reset values and stored defaults
  // ****************************************
  localparam logic [7:0] USER_RST = 8'h00;
  localparam logic [7:0] PHASE_RST = 8'h00;
  localparam logic [7:0] RAIL_RST = 8'h00;
  localparam logic [7:0] GROUP_RST = 8'h00;
  localparam logic [7:0] GUARD_RST = 8'h00;
  localparam logic [7:0] LOCK_RST = 8'h00;
  localparam logic [7:0] FACTORY_FREQ = 8'h58;
  localparam logic FACTORY_VLD = 1'b0;
  localparam logic [7:0] ACCESS_KEY = 8'h5a;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int REF_KHZ = CLK_MHZ * 1000;
  localparam int FSW_UNIT_KHZ = 4;
  localparam int SPREAD_US = 20;
  localparam int SPREAD_CYC = SPREAD_US * CLK_MHZ;
  localparam int EXT_WAIT_MS = 50;
  localparam int EXT_WAIT_CYC_DEF = EXT_WAIT_MS * 1000 * CLK_MHZ;
  localparam int NVM_HOLD_CYC = 16;

  typedef enum logic [2:0] {
    ST_INIT = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN = 3'b100
  } mms_state_t;

  // Nearest integer divisor of the reference for a setting in 4 kHz units
  function automatic logic [15:0] mms_div(input logic [7:0] set);
    int f;
    int q;
    f = int'(set) * FSW_UNIT_KHZ;
    q = 65535;
    if (f != 0) begin
      q = (2 * REF_KHZ / f + 1) / 2;
    end
    if (q < 2) begin
      q = 2;
    end
    if (q > 65535) begin
      q = 65535;
    end
    return q[15:0];
  endfunction : mms_div

endpackage : mms_pkg

// [logic/mms_link_if.sv]
`timescale 1ns/100ps
interface mms_link_if;
  // Sync pin, enable bus, share bus and inter-module link per end
  logic dev_sync_o, dev_sync_oe_n, peer_sync_o, peer_sync_oe_n;
  logic dev_en_o, dev_en_oe_n, peer_en_o, peer_en_oe_n;
  logic [7:0] dev_share_o, peer_share_o;
  logic dev_share_oe_n, peer_share_oe_n;
  logic [4:0] dev_lnk_grp, peer_lnk_grp;
  logic dev_lnk_stb, peer_lnk_stb;
  logic host_enable;
  logic [7:0] cmd_addr, cmd_wdata, cmd_rdata;
  logic cmd_wr, cmd_rd;
  logic sync_line, en_line;
  logic [7:0] share_line;

  // Wire resolution; released lines sit at their pull-up level
  assign sync_line = !dev_sync_oe_n ? dev_sync_o : (!peer_sync_oe_n ? peer_sync_o : 1'b1);
  assign en_line = (dev_en_oe_n | dev_en_o) & (peer_en_oe_n | peer_en_o);
  assign share_line = !dev_share_oe_n ? dev_share_o :
                      (!peer_share_oe_n ? peer_share_o : 8'hff);

  modport dev (
    input sync_line, en_line, share_line, peer_lnk_grp, peer_lnk_stb,
    input host_enable, cmd_addr, cmd_wdata, cmd_wr, cmd_rd,
    output dev_sync_o, dev_sync_oe_n, dev_en_o, dev_en_oe_n,
    output dev_share_o, dev_share_oe_n, dev_lnk_grp, dev_lnk_stb, cmd_rdata
  );

  modport peer (
    input sync_line, en_line, share_line, dev_lnk_grp, dev_lnk_stb, cmd_rdata,
    output peer_sync_o, peer_sync_oe_n, peer_en_o, peer_en_oe_n,
    output peer_share_o, peer_share_oe_n, peer_lnk_grp, peer_lnk_stb,
    output host_enable, cmd_addr, cmd_wdata, cmd_wr, cmd_rd
  );
endinterface : mms_link_if

// [logic/mms_dev.sv]
`timescale 1ns/100ps
module mms_dev
  import mms_pkg::*;
#(
  parameter int EXT_WAIT_CYC = EXT_WAIT_CYC_DEF
) (
  input wire logic mclk,
  input wire logic arst_n,
  mms_link_if.dev lnk,
  input wire logic [3:0] strap_addr,
  input wire logic [7:0] strap_freq,
  input wire logic fault_in,
  input wire logic [7:0] cur_reading,
  output logic sw_clk,
  output logic cycle_start,
  output logic running,
  output logic [7:0] share_ref
);

  // ****************************************
  // State
  // ****************************************
  mms_state_t st_q, st_d;
  logic [7:0] user_q, user_d, phase_q, phase_d, rail_q, rail_d, group_q, group_d;
  logic [7:0] guard_q, guard_d, lock_q, lock_d, freq_q, freq_d, vstat_q, vstat_d;
  logic [7:0] rdata_q, rdata_d, share_o_q, share_o_d, share_ref_q, share_ref_d;
  logic [7:0] sval_q [3];
  logic [7:0] sval_d [3];
  logic [2:0] svld_q, svld_d;
  logic [15:0] div_q, div_d, cnt_q, cnt_d;
  logic [22:0] wait_q, wait_d;
  logic [11:0] spread_q, spread_d;
  logic [4:0] grp_o_q, grp_o_d;
  logic auth_q, auth_d, ext_sel_q, ext_sel_d, seen_q, seen_d, halt_q, halt_d;
  logic sync_prev_q, en_prev_q, flt_prev_q, stb_q, stb_d, sync_oe_n_q, sync_oe_n_d;
  logic sw_clk_q, sw_clk_d, start_q, start_d, run_q, run_d, share_oe_n_q, share_oe_n_d;

  logic sync_rise, en_eff, en_rise, loc_evt, ext_loss, grp_hit, evt, allow;
  logic [1:0] lvl;
  logic [3:0] ph;
  logic [19:0] prod;
  logic [15:0] off;
  logic [22:0] lim;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    st_d = st_q;
    user_d = user_q;
    phase_d = phase_q;
    rail_d = rail_q;
    group_d = group_q;
    guard_d = guard_q;
    lock_d = lock_q;
    freq_d = freq_q;
    auth_d = auth_q;
    sval_d = sval_q;
    svld_d = svld_q;
    ext_sel_d = ext_sel_q;
    rdata_d = 8'h00;
    en_eff = lnk.host_enable & lnk.en_line;
    en_rise = en_eff & ~en_prev_q;
    sync_rise = lnk.sync_line & ~sync_prev_q;
    loc_evt = fault_in & ~flt_prev_q;
    grp_hit = lnk.peer_lnk_stb & (lnk.peer_lnk_grp == group_q[4:0]);
    lvl = lnk.cmd_wdata[1:0];
    // level 3 never; lower levels at or below guard, or key given
    allow = (lvl != 2'd3) && (auth_q || lvl <= guard_q[1:0]);
    // address bits unless offset override set
    ph = phase_q[PH_OVR] ? phase_q[3:0] : strap_addr;
    // offset in sixteenths of the period
    prod = 20'({4'h0, div_q} * {16'h0000, ph});
    off = prod[19:4];
    // first edge may take the full start-up wait
    lim = seen_q ? {6'h00, div_q, 1'b0} : 23'(EXT_WAIT_CYC);

    // Register writes
    if (lnk.cmd_wr) begin
      unique case (lnk.cmd_addr)
        A_PHASE: phase_d = lnk.cmd_wdata;
        A_FREQ: freq_d = lnk.cmd_wdata;
        A_RAIL: rail_d = lnk.cmd_wdata;
        A_GROUP: group_d = lnk.cmd_wdata;
        A_GUARD: guard_d = lnk.cmd_wdata;
        A_LOCK: lock_d = lnk.cmd_wdata;
        A_KEY: auth_d = (lnk.cmd_wdata == ACCESS_KEY);
        A_USER: begin
          user_d = lnk.cmd_wdata;
          ext_sel_d = lnk.cmd_wdata[U_SYNC_EXT];
        end
        // save into store 0 or 1, restore from any of three stores
        A_NVM_OP: begin
          if (lnk.cmd_wdata[NV_SAVE] && allow && lock_q == 8'h00 && lvl != 2'd2) begin
            sval_d[lvl] = freq_q;
            svld_d[lvl] = 1'b1;
          end else if (lnk.cmd_wdata[NV_RESTORE] && allow && svld_q[lvl]) begin
            freq_d = sval_q[lvl];
          end
        end
        default: ;
      endcase
    end

    // Register reads, answer in the next cycle
    if (lnk.cmd_rd) begin
      unique case (lnk.cmd_addr)
        A_PHASE: rdata_d = phase_q;
        A_VSTAT: rdata_d = vstat_q;
        A_FREQ: rdata_d = freq_q;
        A_NVM_OP: rdata_d = {4'h0, auth_q, svld_q};
        A_USER: rdata_d = user_q;
        A_RAIL: rdata_d = rail_q;
        A_GROUP: rdata_d = group_q;
        A_GUARD: rdata_d = guard_q;
        A_LOCK: rdata_d = lock_q;
        default: rdata_d = 8'h00;
      endcase
    end

    // nothing runs until the load has picked a setting
    unique case (st_q)
      ST_INIT: st_d = ST_LOAD;
      ST_LOAD: begin
        // strap when no store holds a value
        if (svld_q[0]) freq_d = sval_q[0];
        else if (svld_q[1]) freq_d = sval_q[1];
        else if (svld_q[2]) freq_d = sval_q[2];
        else freq_d = strap_freq;
        ext_sel_d = user_q[U_SYNC_EXT];
        st_d = ST_RUN;
      end
      ST_RUN: ;
    endcase

    div_d = (st_q == ST_RUN) ? mms_div(freq_q) : div_q;

    // External clock watchdog
    seen_d = seen_q;
    wait_d = wait_q + 23'd1;
    ext_loss = 1'b0;
    if (!ext_sel_q || st_q != ST_RUN || en_rise || (lnk.cmd_wr && lnk.cmd_addr == A_USER)) begin
      wait_d = 23'd0;
      seen_d = 1'b0;
    end else if (sync_rise) begin
      wait_d = 23'd0;
      seen_d = 1'b1;
    end else if (wait_q >= lim) begin
      ext_loss = 1'b1;
      // fall back to the internal reference
      ext_sel_d = 1'b0;
      wait_d = 23'd0;
    end

    // Switching counter, realigned to external edges
    if (st_q != ST_RUN) begin
      cnt_d = 16'h0000;
    end else if (ext_sel_q && sync_rise) begin
      cnt_d = 16'h0000;
    end else if (cnt_q >= div_q - 16'd1) begin
      cnt_d = 16'h0000;
    end else begin
      cnt_d = cnt_q + 16'd1;
    end
    sw_clk_d = (st_q == ST_RUN) && (cnt_d < {1'b0, div_q[15:1]});

    // loss and faults stop switching until re-enable
    evt = ext_loss | loc_evt;
    halt_d = en_eff ? (halt_q | evt | grp_hit) : 1'b0;
    run_d = (st_q == ST_RUN) & en_eff & ~halt_d;
    start_d = run_d & (cnt_d == off);

    // sticky flags, a new event beats a clear
    vstat_d = (lnk.cmd_wr && lnk.cmd_addr == A_CLEAR) ? 8'h00 : vstat_q;
    vstat_d[VS_EXT_FLT] = vstat_d[VS_EXT_FLT] | ext_loss;
    vstat_d[VS_LOC_FLT] = vstat_d[VS_LOC_FLT] | loc_evt;
    vstat_d[VS_GRP_FLT] = vstat_d[VS_GRP_FLT] | grp_hit;

    // hold the enable bus low for the spread time
    spread_d = (spread_q != 12'h000) ? spread_q - 12'd1 : 12'h000;
    if (evt && user_q[U_SPREAD]) begin
      spread_d = 12'(SPREAD_CYC);
    end

    // one-cycle broadcast to the own group
    stb_d = evt & group_q[GRP_BCAST];
    grp_o_d = group_q[4:0];

    // drive sync only when running internally
    sync_oe_n_d = ~(user_q[U_SYNC_OUT] & ~ext_sel_q);

    // master sends current, slave follows share bus
    // phase id zero is the master
    share_oe_n_d = (rail_q[2:0] != 3'd0);
    share_o_d = cur_reading;
    share_ref_d = share_oe_n_q ? lnk.share_line : cur_reading;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_INIT;
      user_q <= USER_RST;
      phase_q <= PHASE_RST;
      rail_q <= RAIL_RST;
      group_q <= GROUP_RST;
      guard_q <= GUARD_RST;
      lock_q <= LOCK_RST;
      freq_q <= 8'h00;
      vstat_q <= 8'h00;
      rdata_q <= 8'h00;
      sval_q[0] <= 8'h00;
      sval_q[1] <= 8'h00;
      sval_q[2] <= FACTORY_FREQ;
      svld_q <= {FACTORY_VLD, 2'b00};
      div_q <= 16'h0000;
      cnt_q <= 16'h0000;
      wait_q <= 23'd0;
      spread_q <= 12'h000;
      grp_o_q <= 5'h00;
      share_o_q <= 8'h00;
      share_ref_q <= 8'h00;
      {auth_q, ext_sel_q, seen_q, halt_q, en_prev_q, flt_prev_q} <= 6'h00;
      // Sync line idles at its pull-up; starting high avoids a false edge
      sync_prev_q <= 1'b1;
      {stb_q, sw_clk_q, start_q, run_q} <= 4'h0;
      sync_oe_n_q <= 1'b1;
      share_oe_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
      user_q <= user_d;
      phase_q <= phase_d;
      rail_q <= rail_d;
      group_q <= group_d;
      guard_q <= guard_d;
      lock_q <= lock_d;
      freq_q <= freq_d;
      vstat_q <= vstat_d;
      rdata_q <= rdata_d;
      sval_q <= sval_d;
      svld_q <= svld_d;
      div_q <= div_d;
      cnt_q <= cnt_d;
      wait_q <= wait_d;
      spread_q <= spread_d;
      grp_o_q <= grp_o_d;
      share_o_q <= share_o_d;
      share_ref_q <= share_ref_d;
      {auth_q, ext_sel_q, seen_q, halt_q} <= {auth_d, ext_sel_d, seen_d, halt_d};
      {sync_prev_q, en_prev_q, flt_prev_q} <= {lnk.sync_line, en_eff, fault_in};
      {stb_q, sw_clk_q, start_q, run_q} <= {stb_d, sw_clk_d, start_d, run_d};
      sync_oe_n_q <= sync_oe_n_d;
      share_oe_n_q <= share_oe_n_d;
    end
  end

  // Pin and user-side outputs, from flops except the enable pull, decoded from the spread count
  assign lnk.dev_sync_o = sw_clk_q;
  assign lnk.dev_sync_oe_n = sync_oe_n_q;
  assign lnk.dev_en_o = 1'b0;
  assign lnk.dev_en_oe_n = (spread_q == 12'h000);
  assign lnk.dev_share_o = share_o_q;
  assign lnk.dev_share_oe_n = share_oe_n_q;
  assign lnk.dev_lnk_grp = grp_o_q;
  assign lnk.dev_lnk_stb = stb_q;
  assign lnk.cmd_rdata = rdata_q;
  assign sw_clk = sw_clk_q;
  assign cycle_start = start_q;
  assign running = run_q;
  assign share_ref = share_ref_q;

endmodule : mms_dev

// [logic/mms_peer.sv]
`timescale 1ns/100ps
module mms_peer
  import mms_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  mms_link_if.peer lnk,
  input wire logic enable_req,
  input wire logic ext_clk_on,
  input wire logic [7:0] freq_set,
  input wire logic is_master,
  input wire logic [7:0] cur_reading,
  input wire logic fault_in,
  input wire logic [4:0] grp_id,
  input wire logic bcast_en,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  output logic [7:0] cmd_rdata,
  output logic grp_fault
);

  // ****************************************
  // State
  // ****************************************
  logic [15:0] cnt_q, cnt_d, div;
  logic [11:0] spread_q, spread_d;
  logic [4:0] hold_q, hold_d;
  logic [7:0] addr_q, wdata_q, rdata_q, share_q;
  logic wr_q, rd_q, rd2_q, clk_q, clk_d, en_q, en_d, flt_prev_q, stb_q, stb_d;
  logic grp_q, grp_d, risky, evt;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    // nominal divisor, the same one the device computes
    div = mms_div(freq_set);
    cnt_d = (cnt_q >= div - 16'd1) ? 16'h0000 : cnt_q + 16'd1;
    clk_d = cnt_d < {1'b0, div[15:1]};
    // enable low around any store or protection write
    risky = cmd_wr && (cmd_addr == A_NVM_OP || cmd_addr == A_GUARD ||
                       cmd_addr == A_KEY || cmd_addr == A_LOCK || cmd_addr == A_USER);
    hold_d = risky ? 5'(NVM_HOLD_CYC) : (hold_q != 5'd0 ? hold_q - 5'd1 : 5'd0);
    en_d = enable_req & ~risky & (hold_q == 5'd0);
    // own fault pulls the shared enable bus
    evt = fault_in & ~flt_prev_q;
    spread_d = evt ? 12'(SPREAD_CYC) : (spread_q != 12'h000 ? spread_q - 12'd1 : 12'h000);
    // group id must match across the rail
    stb_d = evt & bcast_en;
    grp_d = grp_q | (lnk.dev_lnk_stb & (lnk.dev_lnk_grp == grp_id));
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 16'h0000;
      spread_q <= 12'h000;
      hold_q <= 5'd0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      share_q <= 8'h00;
      {wr_q, rd_q, rd2_q, clk_q, en_q, flt_prev_q, stb_q, grp_q} <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
      spread_q <= spread_d;
      hold_q <= hold_d;
      addr_q <= cmd_addr;
      wdata_q <= cmd_wdata;
      rdata_q <= rd2_q ? lnk.cmd_rdata : rdata_q;
      share_q <= cur_reading;
      {wr_q, rd_q, rd2_q, clk_q} <= {cmd_wr, cmd_rd, rd_q, clk_d};
      {en_q, flt_prev_q, stb_q, grp_q} <= {en_d, fault_in, stb_d, grp_d};
    end
  end

  // clock is driven from start whenever asked for
  assign lnk.peer_sync_o = clk_q;
  assign lnk.peer_sync_oe_n = ~ext_clk_on;
  assign lnk.peer_en_o = 1'b0;
  assign lnk.peer_en_oe_n = (spread_q == 12'h000);
  // only the one designated master drives the share bus
  assign lnk.peer_share_o = share_q;
  assign lnk.peer_share_oe_n = ~is_master;
  assign lnk.peer_lnk_grp = grp_id;
  assign lnk.peer_lnk_stb = stb_q;
  assign lnk.host_enable = en_q;
  assign lnk.cmd_addr = addr_q;
  assign lnk.cmd_wdata = wdata_q;
  assign lnk.cmd_wr = wr_q;
  assign lnk.cmd_rd = rd_q;
  assign cmd_rdata = rdata_q;
  assign grp_fault = grp_q;

endmodule : mms_peer

// [verif/mms_link_checker.sv]
`timescale 1ns/100ps
module mms_link_checker
  import mms_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic dev_sync_oe_n,
  input wire logic dev_en_oe_n,
  input wire logic [4:0] dev_lnk_grp,
  input wire logic dev_lnk_stb,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_rdata
);
  // ****************************************
  // Shadow state
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  logic [7:0] usr_q, usr_d, grp_q, grp_d;
  logic [11:0] low_q, low_d;

  // Setup shadows follow host writes; low_q counts cycles of enable pull
  always_comb begin
    usr_d = usr_q;
    grp_d = grp_q;
    low_d = dev_en_oe_n ? 12'h000 : low_q + 12'h001;
    if (cmd_wr && cmd_addr == A_USER) begin
      usr_d = cmd_wdata;
    end
    if (cmd_wr && cmd_addr == A_GROUP) begin
      grp_d = cmd_wdata;
    end
  end

  // Registered on the same edge as the device takes the write
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      usr_q <= USER_RST;
      grp_q <= GROUP_RST;
      low_q <= 12'h000;
    end else begin
      usr_q <= usr_d;
      grp_q <= grp_d;
      low_q <= low_d;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  sequence s_wr_phase;
    cmd_wr && cmd_addr == A_PHASE;
  endsequence
  sequence s_rd_phase;
    cmd_rd && cmd_addr == A_PHASE;
  endsequence

  chk_rd_idle_zero: assert property (!cmd_rd |=> cmd_rdata == 8'h00)
    else $error("read data not zero outside read reply");
  chk_key_hidden: assert property (cmd_rd && cmd_addr == A_KEY |=> cmd_rdata == 8'h00)
    else $error("access key readable");
  chk_phase_back: assert property (s_wr_phase ##1 s_rd_phase |=>
    cmd_rdata[3:0] == $past(cmd_wdata[3:0], 2))
    else $error("phase offset readback wrong");
  chk_sync_out_cfg: assert property (!dev_sync_oe_n |-> $past(usr_q[U_SYNC_OUT]))
    else $error("sync pin driven without output setup");
  chk_spread_gate: assert property ($fell(dev_en_oe_n) |-> usr_q[U_SPREAD])
    else $error("enable bus pulled with spreading off");
  chk_spread_len: assert property ($rose(dev_en_oe_n) |-> low_q == 12'd2500)
    else $error("enable bus pull length wrong");
  chk_bcast_group: assert property (dev_lnk_stb |->
    grp_q[GRP_BCAST] && dev_lnk_grp == grp_q[4:0])
    else $error("broadcast without setup or to wrong group");
  chk_stb_single: assert property (dev_lnk_stb |=> !dev_lnk_stb)
    else $error("broadcast strobe longer than one cycle");
endmodule : mms_link_checker

// [verif/tb_top.sv]
`timescale 1ns/100ps
module tb_top
  import mms_pkg::*;
;
  logic mclk, arst_n, d_fault, p_fault, en_req, ext_on, p_master, p_bcast, c_wr, c_rd;
  logic sw_clk, cycle_start, running, grp_fault;
  logic [3:0] strap_addr;
  logic [4:0] p_grp;
  logic [7:0] strap_freq, d_cur, p_cur, p_freq, c_addr, c_wdata, p_rdata, share_ref, v;
  int num_errors, checks_done, cyc, seed, sf, dv;
  int mdl[int];
  logic [7:0] ra[$] = '{A_PHASE, A_RAIL, A_GROUP, A_GUARD, A_LOCK};
  logic [7:0] rm[$] = '{8'h8f, 8'h07, 8'h9f, 8'h03, 8'hff};

  // two modules on the rail, well inside the limit of eight
  mms_link_if lnk ();
  // Start-up wait must exceed the slowest peer period the random setting can give
  mms_dev #(.EXT_WAIT_CYC(1000)) u_mms_dev (.mclk(mclk), .arst_n(arst_n), .lnk(lnk.dev),
    .strap_addr(strap_addr), .strap_freq(strap_freq), .fault_in(d_fault), .cur_reading(d_cur),
    .sw_clk(sw_clk), .cycle_start(cycle_start), .running(running), .share_ref(share_ref));
  mms_peer u_mms_peer (.mclk(mclk), .arst_n(arst_n), .lnk(lnk.peer), .enable_req(en_req),
    .ext_clk_on(ext_on), .freq_set(p_freq), .is_master(p_master), .cur_reading(p_cur),
    .fault_in(p_fault), .grp_id(p_grp), .bcast_en(p_bcast), .cmd_addr(c_addr),
    .cmd_wdata(c_wdata), .cmd_wr(c_wr), .cmd_rd(c_rd), .cmd_rdata(p_rdata),
    .grp_fault(grp_fault));
  mms_link_checker u_mms_link_checker (.mclk(mclk), .arst_n(arst_n),
    .dev_sync_oe_n(lnk.dev_sync_oe_n), .dev_en_oe_n(lnk.dev_en_oe_n),
    .dev_lnk_grp(lnk.dev_lnk_grp), .dev_lnk_stb(lnk.dev_lnk_stb), .cmd_addr(lnk.cmd_addr),
    .cmd_wdata(lnk.cmd_wdata), .cmd_wr(lnk.cmd_wr), .cmd_rd(lnk.cmd_rd),
    .cmd_rdata(lnk.cmd_rdata));

  // ****************************************
  // Clock, watchdog and helpers
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Ceiling well above the longest expected run
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors = num_errors + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_n(input string what, input int exp, input int got);
    checks_done++;
    if (got != exp) begin
      num_errors++;
      $display("FAIL %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_n

  // Write leaves the strobe up so a read may follow with no gap
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    c_wr <= 1'b1;
    c_rd <= 1'b0;
    c_addr <= a;
    c_wdata <= d;
  endtask : wr

  // Peer returns read data two edges after it takes the read
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk);
    c_rd <= 1'b1;
    c_wr <= 1'b0;
    c_addr <= a;
    @(posedge mclk);
    c_rd <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk(what, exp, p_rdata);
  endtask : rd

  task automatic idle(input int n);
    @(posedge mclk);
    c_wr <= 1'b0;
    c_rd <= 1'b0;
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle

  task automatic do_reset();
    @(posedge mclk);
    arst_n <= 1'b0;
    strap_freq <= sf[7:0];
    p_freq <= sf[7:0];
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    idle(40);
  endtask : do_reset

  // Spacing of cycle start pulses in reference cycles
  task automatic period(input int exp);
    int n;
    n = 0;
    while (cycle_start !== 1'b1 && n < 2000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (cycle_start !== 1'b1 && n < 2000);
    chk_n("switch period", exp, n);
  endtask : period

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {d_fault, p_fault, ext_on, p_master, p_bcast, c_wr, c_rd} = '0;
    {strap_addr, p_grp, d_cur, p_cur, c_addr, c_wdata, strap_freq, p_freq} = '0;
    arst_n = 1'b0;
    en_req = 1'b1;
    num_errors = 0;
    checks_done = 0;
    cyc = 0;
    seed = 91104;
    for (int i = 0; i < 3; i++) begin
      sf = 100 + ($unsigned($random(seed)) % 128);
      dv = (2 * REF_KHZ / (sf * FSW_UNIT_KHZ) + 1) / 2;
      do_reset();
      period(dv);
      chk("running", 8'h01, {7'h00, running});
    end
    $display("test strap divider done");
    foreach (ra[i]) rd(ra[i], 8'h00, "reset value");
    foreach (ra[i]) begin
      v = $random(seed) & rm[i];
      wr(ra[i], v);
      mdl[ra[i]] = v;
    end
    wr(A_VSTAT, 8'hff);
    wr(A_KEY, 8'h33);
    wr(8'h10, 8'hff);
    foreach (ra[i]) rd(ra[i], mdl[ra[i]], "readback");
    rd(A_VSTAT, 8'h00, "status");
    rd(A_KEY, 8'h00, "key");
    rd(8'h10, 8'h00, "unmapped");
    wr(A_PHASE, 8'h85);
    rd(A_PHASE, 8'h85, "phase");
    $display("test registers done");
    wr(A_GUARD, 8'h03);
    wr(A_LOCK, 8'h00);
    wr(A_NVM_OP, 8'h04);
    idle(20);
    rd(A_NVM_OP, 8'h01, "user store saved");
    wr(A_LOCK, 8'h01);
    wr(A_NVM_OP, 8'h05);
    idle(20);
    rd(A_NVM_OP, 8'h01, "locked save");
    wr(A_KEY, ACCESS_KEY);
    rd(A_NVM_OP, 8'h09, "authorised");
    $display("test stores done");
    do_reset();
    ext_on <= 1'b1;
    wr(A_USER, 8'h02);
    idle(400);
    rd(A_VSTAT, 8'h00, "ext clock ok");
    chk("running ext", 8'h01, {7'h00, running});
    ext_on <= 1'b0;
    idle(2 * dv + 50);
    rd(A_VSTAT, 8'h08, "clock loss");
    chk("halted", 8'h00, {7'h00, running});
    idle(100);
    rd(A_VSTAT, 8'h08, "loss sticky");
    en_req <= 1'b0;
    idle(5);
    en_req <= 1'b1;
    idle(30);
    period(dv);
    wr(A_CLEAR, 8'h00);
    rd(A_VSTAT, 8'h00, "cleared");
    ext_on <= 1'b1;
    wr(A_USER, 8'h02);
    idle(400);
    rd(A_VSTAT, 8'h00, "resync");
    chk("running resync", 8'h01, {7'h00, running});
    $display("test sync loss done");
    ext_on <= 1'b0;
    p_grp <= 5'd9;
    wr(A_USER, 8'h04);
    wr(A_GROUP, 8'h89);
    wr(A_CLEAR, 8'h00);
    idle(40);
    d_fault <= 1'b1;
    idle(100);
    chk("enable bus", 8'h00, {7'h00, lnk.en_line});
    chk("peer group fault", 8'h01, {7'h00, grp_fault});
    idle(2450);
    chk("enable released", 8'h01, {7'h00, lnk.en_line});
    rd(A_VSTAT, 8'h20, "local fault");
    d_fault <= 1'b0;
    wr(A_CLEAR, 8'h00);
    p_grp <= 5'd3;
    p_bcast <= 1'b1;
    p_fault <= 1'b1;
    idle(10);
    p_fault <= 1'b0;
    rd(A_VSTAT, 8'h00, "other group");
    p_grp <= 5'd9;
    p_fault <= 1'b1;
    idle(10);
    p_fault <= 1'b0;
    rd(A_VSTAT, 8'h10, "own group");
    $display("test faults done");
    p_cur <= $random(seed);
    d_cur <= $random(seed);
    p_master <= 1'b1;
    wr(A_RAIL, 8'h01);
    idle(10);
    chk("slave share", p_cur, share_ref);
    p_master <= 1'b0;
    wr(A_RAIL, 8'h00);
    wr(A_USER, 8'h01);
    idle(10);
    chk("master share", d_cur, share_ref);
    chk("share line", d_cur, lnk.share_line);
    chk("sync out", 8'h00, {7'h00, lnk.dev_sync_oe_n});
    $display("test share done");
    end_sim();
  end
endmodule : tb_top
